// ---- design/pls_regs.sv ----
// Purpose: Extended configuration registers of one switch port over AHB-Lite.
// Assumes: Single word transfers; the port type strap is stable in operation.
// Notes:   Zero wait states; every response is OKAY, unmapped words read zero.
`timescale 1ns/1ps
`default_nettype none
module pls_regs (
   input  wire logic             CLK_I,
   input  wire logic             RESET_N_I,
   input  wire logic             PORT_UP_I,
   input  wire logic             HSEL_I,
   input  wire logic [31:0]      HADDR_I,
   input  wire logic [1:0]       HTRANS_I,
   input  wire logic             HWRITE_I,
   input  wire logic [2:0]       HSIZE_I,
   input  wire logic [31:0]      HWDATA_I,
   input  wire logic             HREADY_I,
   input  wire logic             CAP_LOAD_I,
   input  wire pls_pkg::pls_cap_t CAP_LOAD_DATA_I,
   output var  logic [31:0]      HRDATA_O,
   output var  logic             HREADYOUT_O,
   output var  logic             HRESP_O,
   output var  pls_pkg::pls_lat_t NOSNOOP_O,
   output var  pls_pkg::pls_ctl_t L1SS_CTL_O,
   output var  pls_pkg::pls_cap_t L1SS_CAP_O
);

   logic                acc;
   logic                dp_wr;
   logic [11:0]         dp_addr;
   pls_pkg::pls_lat_t   next_lat;
   pls_pkg::pls_ctl_t   next_ctl;
   pls_pkg::pls_cap_t   next_cap;

   // Builds the word seen at an offset from the register values given.
   function automatic logic [31:0] rd_word(
      input logic [11:0]       a,
      input logic              up,
      input pls_pkg::pls_lat_t l,
      input pls_pkg::pls_ctl_t c,
      input pls_pkg::pls_cap_t p
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (a)
         pls_pkg::OFS_NS_LAT: begin
            if (up) begin
               w[pls_pkg::LAT_VAL_LSB +: 10] = l.value;
               w[pls_pkg::LAT_SCL_LSB +: 3]  = l.scale;
            end
         end
         pls_pkg::OFS_L1_HDR: begin
            w[15:0]  = pls_pkg::ID_L1SS;
            w[19:16] = pls_pkg::CAP_VER;
            w[31:20] = up ? pls_pkg::NXT_UP : pls_pkg::NXT_DN;
         end
         pls_pkg::OFS_L1_CAP: begin
            w[pls_pkg::PM_L11_BIT] = p.pm_l11;
            w[pls_pkg::ASPM_BIT]   = p.aspm_l11;
            w[pls_pkg::L1SS_BIT]   = p.l1ss;
         end
         pls_pkg::OFS_L1_CTL1: begin
            w[pls_pkg::PM_L11_BIT] = c.pm_l11;
            w[pls_pkg::ASPM_BIT]   = c.aspm_l11;
         end
         pls_pkg::OFS_CNT_HDR: begin
            if (!up) begin
               w[15:0]  = pls_pkg::ID_CNT;
               w[19:16] = pls_pkg::CAP_VER;
               w[31:20] = pls_pkg::NXT_END;
            end
         end
         pls_pkg::OFS_CNT_CAP: begin
            if (!up) begin
               w[4:0] = pls_pkg::MSG_NUM;
            end
         end
         default: begin
            w = 32'h0000_0000;
         end
      endcase
      return w;
   endfunction

   // The slave never stretches a transfer, so the bus ready is ours alone.
   assign HREADYOUT_O = 1'h1;
   assign HRESP_O     = pls_pkg::HRESP_OKAY;
   // The transfer size is not decoded: every access is taken as a whole word.
   assign acc         = HSEL_I & HREADY_I & HTRANS_I[1];

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         dp_wr   <= 1'h0;
         dp_addr <= 12'h000;
      end else begin
         dp_wr   <= acc & HWRITE_I;
         dp_addr <= HADDR_I[11:0];
      end
   end

   always_comb begin
      next_lat = NOSNOOP_O;
      next_ctl = L1SS_CTL_O;
      if (dp_wr && PORT_UP_I && dp_addr == pls_pkg::OFS_NS_LAT) begin
         next_lat.value = HWDATA_I[pls_pkg::LAT_VAL_LSB +: 10];
         next_lat.scale = HWDATA_I[pls_pkg::LAT_SCL_LSB +: 3];
      end
      if (dp_wr && dp_addr == pls_pkg::OFS_L1_CTL1) begin
         next_ctl.pm_l11   = HWDATA_I[pls_pkg::PM_L11_BIT];
         next_ctl.aspm_l11 = HWDATA_I[pls_pkg::ASPM_BIT];
      end
   end

   // Capability defaults are replaced only by the side-band or EEPROM loader.
   always_comb begin
      next_cap = L1SS_CAP_O;
      if (CAP_LOAD_I) begin
         next_cap = CAP_LOAD_DATA_I;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         NOSNOOP_O.value <= pls_pkg::LAT_VAL_RST;
         NOSNOOP_O.scale <= pls_pkg::LAT_SCL_RST;
      end else begin
         NOSNOOP_O <= next_lat;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         L1SS_CTL_O.pm_l11   <= pls_pkg::CTL_RST;
         L1SS_CTL_O.aspm_l11 <= pls_pkg::CTL_RST;
      end else begin
         L1SS_CTL_O <= next_ctl;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         L1SS_CAP_O.pm_l11   <= pls_pkg::CAP_PM_RST;
         L1SS_CAP_O.aspm_l11 <= pls_pkg::CAP_ASPM_RST;
         L1SS_CAP_O.l1ss     <= pls_pkg::CAP_L1SS_RST;
      end else begin
         L1SS_CAP_O <= next_cap;
      end
   end

   // Read data is taken from the next values, so a read right behind a
   // write to the same word already returns the written data.
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (acc && !HWRITE_I) begin
         HRDATA_O <= rd_word(HADDR_I[11:0], PORT_UP_I, next_lat, next_ctl, next_cap);
      end
   end

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   sequence s_rd(logic [11:0] a);
      acc && !HWRITE_I && HADDR_I[11:0] == a;
   endsequence

   sequence s_wr(logic [11:0] a);
      acc && HWRITE_I && HADDR_I[11:0] == a;
   endsequence

   property p_lat_val;
      s_wr(pls_pkg::OFS_NS_LAT) ##1 PORT_UP_I |=> NOSNOOP_O.value == $past(HWDATA_I[25:16]);
   endproperty
   a_lat_val: assert property (p_lat_val) else $error("no-snoop value not written");

   property p_lat_scl;
      s_wr(pls_pkg::OFS_NS_LAT) ##1 PORT_UP_I |=> NOSNOOP_O.scale == $past(HWDATA_I[28:26]);
   endproperty
   a_lat_scl: assert property (p_lat_scl) else $error("no-snoop scale not written");

   property p_hdr_id;
      s_rd(pls_pkg::OFS_L1_HDR) |=> HRDATA_O[15:0] == 16'h001e;
   endproperty
   a_hdr_id: assert property (p_hdr_id) else $error("substates header id wrong");

   property p_ver;
      (s_rd(pls_pkg::OFS_L1_HDR) or (s_rd(pls_pkg::OFS_CNT_HDR) ##0 !PORT_UP_I))
         |=> HRDATA_O[19:16] == 4'h1;
   endproperty
   a_ver: assert property (p_ver) else $error("capability version wrong");

   property p_nxt;
      s_rd(pls_pkg::OFS_L1_HDR) |=>
         HRDATA_O[31:20] == ($past(PORT_UP_I) ? 12'h260 : 12'h250);
   endproperty
   a_nxt: assert property (p_nxt) else $error("substates next pointer wrong");

   property p_cap_rst;
      $rose(RESET_N_I) |->
         L1SS_CAP_O.l1ss && !L1SS_CAP_O.aspm_l11 && L1SS_CAP_O.pm_l11;
   endproperty
   a_cap_rst: assert property (disable iff (1'h0) p_cap_rst)
      else $error("cap reset wrong");

   property p_cap_load;
      CAP_LOAD_I |=> L1SS_CAP_O == $past(CAP_LOAD_DATA_I);
   endproperty
   a_cap_load: assert property (p_cap_load) else $error("cap load lost");

   property p_ctl;
      s_wr(pls_pkg::OFS_L1_CTL1) |=> ##1
         L1SS_CTL_O == {$past(HWDATA_I[3]), $past(HWDATA_I[1])};
   endproperty
   a_ctl: assert property (p_ctl) else $error("control enables not written");

   property p_cnt_hdr;
      s_rd(pls_pkg::OFS_CNT_HDR) ##0 !PORT_UP_I |=>
         HRDATA_O[15:0] == 16'h001d && HRDATA_O[31:20] == 12'h000;
   endproperty
   a_cnt_hdr: assert property (p_cnt_hdr) else $error("containment header wrong");

   property p_msg;
      s_rd(pls_pkg::OFS_CNT_CAP) ##0 !PORT_UP_I |=> HRDATA_O == 32'h0000_0001;
   endproperty
   a_msg: assert property (p_msg) else $error("message number wrong");

   property p_ctl2;
      s_rd(pls_pkg::OFS_L1_CTL2) or (s_rd(pls_pkg::OFS_NS_LAT) ##0 !PORT_UP_I)
         |=> HRDATA_O == 32'h0000_0000;
   endproperty
   a_ctl2: assert property (p_ctl2) else $error("reserved word not zero");

   property p_ptr_end;
      s_rd(pls_pkg::OFS_CNT_HDR) ##0 !PORT_UP_I |=> HRDATA_O[31:20] == 12'h000;
   endproperty
   a_ptr_end: assert property (p_ptr_end) else $error("chain not ended");

   // Reset values, read-only hold and reserved zeros. The latency and control hold checks look
   // at the registered data phase, so a write may only land one edge after its acceptance.

   property p_lat_rst;
      $rose(RESET_N_I) |->
         NOSNOOP_O == 13'h0000;
   endproperty
   a_lat_rst: assert property (disable iff (1'h0) p_lat_rst)
      else $error("latency reset wrong");

   property p_ctl_rst;
      $rose(RESET_N_I) |->
         L1SS_CTL_O == 2'h0;
   endproperty
   a_ctl_rst: assert property (disable iff (1'h0) p_ctl_rst)
      else $error("control reset wrong");

   property p_lat_hold;
      !(dp_wr && PORT_UP_I && dp_addr == pls_pkg::OFS_NS_LAT) |=>
         $stable(NOSNOOP_O);
   endproperty
   a_lat_hold: assert property (p_lat_hold) else $error("latency changed unwritten");

   property p_lat_dn;
      s_wr(pls_pkg::OFS_NS_LAT) ##1 !PORT_UP_I |=>
         $stable(NOSNOOP_O);
   endproperty
   a_lat_dn: assert property (p_lat_dn) else $error("downstream latency written");

   property p_ctl_hold;
      !(dp_wr && dp_addr == pls_pkg::OFS_L1_CTL1) |=>
         $stable(L1SS_CTL_O);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold) else $error("control changed unwritten");

   property p_cap_hold;
      !CAP_LOAD_I |=>
         $stable(L1SS_CAP_O);
   endproperty
   a_cap_hold: assert property (p_cap_hold) else $error("capability changed unloaded");

   property p_cap_rd;
      s_rd(pls_pkg::OFS_L1_CAP) ##0 !CAP_LOAD_I |=>
         HRDATA_O[4] == $past(L1SS_CAP_O.l1ss) && HRDATA_O[1] == $past(L1SS_CAP_O.pm_l11);
   endproperty
   a_cap_rd: assert property (p_cap_rd) else $error("capability read wrong");

   property p_cap_rsv;
      s_rd(pls_pkg::OFS_L1_CAP) |=>
         (HRDATA_O & 32'hffff_ffe5) == 32'h0000_0000;
   endproperty
   a_cap_rsv: assert property (p_cap_rsv) else $error("capability reserved not zero");

   property p_ctl_rsv;
      s_rd(pls_pkg::OFS_L1_CTL1) |=>
         (HRDATA_O & 32'hffff_fff5) == 32'h0000_0000;
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved not zero");

   property p_lat_rsv;
      s_rd(pls_pkg::OFS_NS_LAT) |=>
         (HRDATA_O & 32'he000_ffff) == 32'h0000_0000;
   endproperty
   a_lat_rsv: assert property (p_lat_rsv) else $error("latency reserved not zero");

   property p_up_cnt;
      (s_rd(pls_pkg::OFS_CNT_HDR) or s_rd(pls_pkg::OFS_CNT_CAP)) ##0 PORT_UP_I |=>
         HRDATA_O == 32'h0000_0000;
   endproperty
   a_up_cnt: assert property (p_up_cnt) else $error("upstream containment not zero");

endmodule
`default_nettype wire

// ---- design/pls_pkg.sv ----
// Purpose: Constants and types for the latency, L1 substates and containment registers.
// Assumes: Register offsets are the low twelve bits of the byte address.
package pls_pkg;

   localparam logic [11:0] OFS_NS_LAT   = 12'h234;
   localparam logic [11:0] OFS_L1_HDR   = 12'h240;
   localparam logic [11:0] OFS_L1_CAP   = 12'h244;
   localparam logic [11:0] OFS_L1_CTL1  = 12'h248;
   localparam logic [11:0] OFS_L1_CTL2  = 12'h24c;
   localparam logic [11:0] OFS_CNT_HDR  = 12'h250;
   localparam logic [11:0] OFS_CNT_CAP  = 12'h254;

   localparam logic [15:0] ID_L1SS      = 16'h001e;
   localparam logic [15:0] ID_CNT       = 16'h001d;
   localparam logic [3:0]  CAP_VER      = 4'h1;
   localparam logic [11:0] NXT_UP       = 12'h260;
   localparam logic [11:0] NXT_DN       = 12'h250;
   localparam logic [11:0] NXT_END      = 12'h000;
   localparam logic [4:0]  MSG_NUM      = 5'h01;

   localparam int          LAT_VAL_LSB  = 16;
   localparam int          LAT_SCL_LSB  = 26;
   localparam int          PM_L11_BIT   = 1;
   localparam int          ASPM_BIT     = 3;
   localparam int          L1SS_BIT     = 4;

   localparam logic [9:0]  LAT_VAL_RST  = 10'h000;
   localparam logic [2:0]  LAT_SCL_RST  = 3'h0;
   localparam logic        CAP_PM_RST   = 1'h1;
   localparam logic        CAP_ASPM_RST = 1'h0;
   localparam logic        CAP_L1SS_RST = 1'h1;
   localparam logic        CTL_RST      = 1'h0;

   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
   localparam logic        HRESP_OKAY   = 1'h0;

   typedef struct packed {
      logic [2:0] scale;
      logic [9:0] value;
   } pls_lat_t;

   typedef struct packed {
      logic aspm_l11;
      logic pm_l11;
   } pls_ctl_t;

   typedef struct packed {
      logic l1ss;
      logic aspm_l11;
      logic pm_l11;
   } pls_cap_t;

endpackage

// ---- verif/pls_regs_bench.sv ----
// Purpose: Self-checking bench for the port's extended configuration registers.
// Assumes: Zero wait states; hready is the slave's own hreadyout.
// Notes:   Upstream map, writes, capability load, second reset, then downstream.
`timescale 1ns/1ps
`default_nettype none
module pls_regs_bench;
   logic              clk;
   logic              reset_n;
   logic              port_up;
   logic              hsel;
   logic [31:0]       haddr;
   logic [1:0]        htrans;
   logic              hwrite;
   logic [2:0]        hsize;
   logic [31:0]       hwdata;
   logic              cap_load;
   pls_pkg::pls_cap_t cap_data;
   logic [31:0]       hrdata;
   logic              hready;
   logic              hresp;
   pls_pkg::pls_lat_t nosnoop;
   pls_pkg::pls_ctl_t ctl;
   pls_pkg::pls_cap_t cap;
   int                fails;
   int                samples_checked;
   logic [31:0]       rd;

   pls_regs pls_regs_inst (.CLK_I(clk), .RESET_N_I(reset_n), .PORT_UP_I(port_up),
      .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
      .HWDATA_I(hwdata), .HREADY_I(hready), .CAP_LOAD_I(cap_load), .CAP_LOAD_DATA_I(cap_data),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .NOSNOOP_O(nosnoop),
      .L1SS_CTL_O(ctl), .L1SS_CAP_O(cap));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_port(input string what, input logic [12:0] exp, input logic [12:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Entered just after a rising edge; every bus signal change lands by non-blocking assignment, rd is set blocking.
   task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= pls_pkg::HTRANS_NSEQ;
      hwrite <= wr;
      haddr  <= {20'h00000, ofs};
      hsize  <= 3'h2;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
      bus(1'b1, ofs, d);
   endtask

   task automatic rdw(input logic [11:0] ofs, input logic [31:0] exp);
      bus(1'b0, ofs, 32'h00000000);
      cmp_word($sformatf("word %h", ofs), exp, rd);
   endtask

   task automatic do_reset;
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
   endtask

   task automatic load_cap(input pls_pkg::pls_cap_t d);
      cap_load <= 1'b1;
      cap_data <= d;
      @(posedge clk);
      cap_load <= 1'b0;
      @(posedge clk);
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      tally_and_finish();
   end

   initial begin
      fails = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      port_up = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      cap_load = 1'b0;
      cap_data = 3'h0;
      do_reset();
      rdw(12'h234, 32'h00000000);
      rdw(12'h240, {pls_pkg::NXT_UP, 4'h1, 16'h001e});
      rdw(12'h244, 32'h00000012);
      rdw(12'h248, 32'h00000000);
      rdw(12'h24c, 32'h00000000);
      cmp_port("resp", 13'h0000, {12'h000, hresp});
      cmp_port("ready", 13'h0001, {12'h000, hready});
      rdw(12'h250, 32'h00000000);
      rdw(12'h254, 32'h00000000);
      cmp_port("cap out", 13'h0005, {10'h000, cap});
      $display("test reset map done");
      wr(12'h234, 32'hffffffff);
      rdw(12'h234, 32'h1fff0000);
      wr(12'h234, 32'ha5a5a5a5);
      rdw(12'h234, 32'h05a50000);
      cmp_port("lat out", 13'h05a5, nosnoop);
      wr(12'h248, 32'hffffffff);
      rdw(12'h248, 32'h0000000a);
      cmp_port("ctl out", 13'h0003, {11'h000, ctl});
      wr(12'h240, 32'hffffffff);
      wr(12'h244, 32'hffffffff);
      wr(12'h24c, 32'hffffffff);
      rdw(12'h240, 32'h2601001e);
      rdw(12'h244, 32'h00000012);
      rdw(12'h24c, 32'h00000000);
      $display("test writes done");
      load_cap(3'h2);
      rdw(12'h244, 32'h00000008);
      load_cap(3'h4);
      rdw(12'h244, 32'h00000010);
      cmp_port("cap load out", 13'h0004, {10'h000, cap});
      do_reset();
      rdw(12'h244, 32'h00000012);
      rdw(12'h248, 32'h00000000);
      rdw(12'h234, 32'h00000000);
      $display("test load and reset done");
      port_up <= 1'b0;
      @(posedge clk);
      rdw(12'h240, {pls_pkg::NXT_DN, 4'h1, 16'h001e});
      rdw(12'h250, 32'h0001001d);
      rdw(12'h254, 32'h00000001);
      wr(12'h254, 32'hffffffff);
      rdw(12'h254, 32'h00000001);
      wr(12'h234, 32'hffffffff);
      rdw(12'h234, 32'h00000000);
      cmp_port("lat out dn", 13'h0000, nosnoop);
      wr(12'h248, 32'h00000008);
      rdw(12'h248, 32'h00000008);
      wr(12'h248, 32'h0000000a);
      rdw(12'h248, 32'h0000000a);
      cmp_port("ctl out dn", 13'h0003, {11'h000, ctl});
      $display("test downstream done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
